// >>> shared/afc_consts.svh
// Register offsets, field positions, reset values and timing counts of the frame/chop control.
// Assumes inclusion by bare name from the package and from every design module.
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
`define AFC_ADDR_FRAME    16'h2100
`define AFC_ADDR_CHOP     16'h2106
`define AFC_ADDR_DEC      16'h210C
`define AFC_ADDR_RATE     16'h2110
`define AFC_ADDR_STAT     16'h2114
`define AFC_RST_FRAME     8'hB0
`define AFC_RST_CHOP      8'h00
`define AFC_RST_DEC       8'h02
`define AFC_RST_RATE      8'h00
`define AFC_SLOTS_MSB     7
`define AFC_SLOTS_LSB     4
`define AFC_CHOP_MSB      3
`define AFC_CHOP_LSB      2
`define AFC_FIRLEN_MSB    2
`define AFC_FIRLEN_LSB    1
`define AFC_REMEN_BIT     5
`define AFC_RATE_BIT      0
`define AFC_FIRLEN_22     2'h2
`define AFC_CHOP_AUTO     2'h0
`define AFC_CHOP_POS      2'h1
`define AFC_CHOP_NEG      2'h2
`define AFC_CHOP_HOLD     2'h3
`define AFC_MAX_SLOTS     4'hB
`define AFC_RAM_BASE      16'h0000
`define AFC_RAM_REMOTE    16'h0010
`define AFC_SAMPLE_SHIFT  9
`define AFC_CONV_HALF_F   4'h1
`define AFC_CONV_HALF_S   4'h3
`define AFC_PULSE_HALF    8'h08
`define AFC_RTM_LAST      2'h3
`endif

// >>> shared/afc_pkg.sv
// Types shared by the frame/chop control and its test bench.
// Assumes afc_consts.svh is on the include path.
`include "afc_consts.svh"
package afc_pkg;
    typedef enum logic [0:0] {
        AFC_FS_SLOT   = 1'h0,
        AFC_FS_SETTLE = 1'h1
    } afc_fsm_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } afc_reg_req_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [31:0] data;
    } afc_ram_wr_t;

    typedef struct packed {
        logic o;
        logic oe;
    } afc_pin_t;
endpackage

// >>> hw/afc_decim.sv
// Decimating accumulator for a one-bit modulator stream.
// Assumes tick and dump are one-cycle pulses in the clk domain.
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"
module afc_decim #(
    parameter int W = 22
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         tick,
    input  wire logic         mod_bit,
    input  wire logic         dump,
    input  wire logic         len22,
    output logic [W-1:0]      result,
    output logic              valid
);
    import afc_pkg::*;
    generate
        if (W < 22) begin : g_bad
            $error("afc_decim: W must be at least 22");
        end
    endgenerate
    typedef struct packed {
        logic signed [W-1:0] acc;
        logic [W-1:0]        res;
        logic                vld;
    } afc_dec_st_t;
    localparam logic signed [W-1:0] ONE = W'(1);
    afc_dec_st_t         st_q, st_d;
    logic signed [W-1:0] lim;
    always_comb begin
        st_d     = st_q;
        st_d.vld = 1'h0;
        // Clipping to the selected width keeps a 21-bit result sign-correct in W bits
        lim = len22 ? {1'h0, {(W-1){1'h1}}} : {2'h0, {(W-2){1'h1}}};
        if (dump) begin
            st_d.res = st_q.acc;
            st_d.vld = 1'h1;
            st_d.acc = '0;
        end else if (tick) begin
            if (mod_bit && (st_q.acc < lim)) st_d.acc = st_q.acc + ONE;
            else if (!mod_bit && (st_q.acc > -lim)) st_d.acc = st_q.acc - ONE;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) st_q <= '0;
        else     st_q <= st_d;
    end
    assign result = st_q.res;
    assign valid  = st_q.vld;
endmodule
`default_nettype wire

// >>> hw/afc_chop.sv
// Reference chop state: applies the chop mode once per frame at the settle start.
// Assumes update is a one-cycle pulse at the start of the inserted settle cycle.
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"
module afc_chop #(
    parameter int ACC_FRAMES = 8
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       update,
    input  wire logic [1:0] mode,
    output logic            invert
);
    import afc_pkg::*;
    generate
        if (ACC_FRAMES < 1) begin : g_bad
            $error("afc_chop: ACC_FRAMES must be at least 1");
        end
    endgenerate
    localparam int CW = $clog2(ACC_FRAMES + 1);
    typedef struct packed {
        logic          inv;
        logic          par;
        logic [CW-1:0] frm;
    } afc_chop_st_t;
    afc_chop_st_t st_q, st_d;
    logic         last;
    always_comb begin
        st_d = st_q;
        last = (st_q.frm == CW'(ACC_FRAMES - 1));
        if (update) begin
            st_d.frm = last ? '0 : st_q.frm + CW'(1);
            case (mode)
                `AFC_CHOP_POS:  st_d.inv = 1'h0;
                `AFC_CHOP_NEG:  st_d.inv = 1'h1;
                `AFC_CHOP_HOLD: st_d.inv = last ? st_q.inv : ~st_q.inv;
                default: begin
                    // Interval ends alternate high, low, high regardless of frame count
                    st_d.inv = last ? ~st_q.par : ~st_q.inv;
                    if (last) st_d.par = ~st_q.par;
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (rst) st_q <= '0;
        else     st_q <= st_d;
    end
    assign invert = st_q.inv;

    AST_AUTO_TOGGLE: assert property (@(posedge clk) disable iff (rst)
        (update && mode == `AFC_CHOP_AUTO && last) |=> (invert == !$past(st_q.par)))
        else $error("auto chop did not alternate at interval end");
    AST_HOLD_LAST: assert property (@(posedge clk) disable iff (rst)
        (update && mode == `AFC_CHOP_HOLD && last) |=> $stable(invert))
        else $error("hold chop changed at interval end");
endmodule
`default_nettype wire

// >>> hw/afc_frame_ctrl.sv
// Frame, slot and chop control around a multiplexed delta-sigma converter.
// Assumes inputs synchronous to CLK_SYS and a RAM that takes one word per write strobe.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"
module afc_frame_ctrl #(
    parameter int ACC_FRAMES = 8,
    parameter int SAMPLE_W   = 22
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST,
    input  wire afc_pkg::afc_reg_req_t REG_REQ,
    output logic [7:0]                REG_RDATA,
    input  wire logic                 SLOW_CLOCK_32K,
    input  wire logic                 LOCAL_MOD_BIT,
    output logic                      CONVERTER_CLOCK,
    output logic                      CHOP_INVERT,
    output logic                      FRAME_SYNC,
    output logic                      CE_START,
    output logic                      RTM_VALID,
    output logic [1:0]                RTM_INDEX,
    output afc_pkg::afc_ram_wr_t      RAM_WR,
    input  wire logic                 REMOTE_LINK_POS_I,
    input  wire logic                 REMOTE_LINK_NEG_I,
    output afc_pkg::afc_pin_t         REMOTE_LINK_POS,
    output afc_pkg::afc_pin_t         REMOTE_LINK_NEG
);
    import afc_pkg::*;
    generate
        if (SAMPLE_W != 22) begin : g_bad
            $error("afc_frame_ctrl: SAMPLE_W must be 22");
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        afc_fsm_t    fsm;
        logic [3:0]  slot;
        logic [3:0]  wr_slot;
        logic        loc_pend;
        logic        slow_clock_32k_prev;
        logic [3:0]  conv_cnt;
        logic        conv_clk;
        logic        conv_tick;
        logic [7:0]  pulse_cnt;
        logic        pulse_ph;
        logic        link_tick;
        logic        link_bit;
        logic        frame_sync;
        logic        ce_start;
        logic        rtm_valid;
        logic [1:0]  rtm_idx;
        afc_ram_wr_t ram;
        logic        rem_pend;
        logic [31:0] rem_word;
        logic [7:0]  frame_cfg;
        logic [7:0]  chop_cfg;
        logic [7:0]  dec_cfg;
        logic [7:0]  rate_cfg;
        logic [7:0]  rdata;
        afc_pin_t    pos;
        afc_pin_t    neg;
    } afc_main_st_t;

    afc_main_st_t        st_q, st_d;
    logic                slow_clock_32k_rise;
    logic                slot_end;
    logic                settle_start;
    logic [3:0]          n_slots;
    logic                len22;
    logic                rem_en;
    logic                fast;
    logic [1:0]          chop_mode;
    logic [SAMPLE_W-1:0] loc_res;
    logic                loc_vld;
    logic [SAMPLE_W-1:0] rem_res;
    logic                rem_vld;
    logic                chop_inv;

    function automatic logic [31:0] sample_word(input logic [SAMPLE_W-1:0] s);
        sample_word = {s[SAMPLE_W-1], s, {`AFC_SAMPLE_SHIFT{1'h0}}};
    endfunction

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    always_comb begin
        n_slots   = st_q.frame_cfg[`AFC_SLOTS_MSB:`AFC_SLOTS_LSB];
        // Zero would wrap to a sixteen-slot frame, so it runs one slot; above eleven is clipped
        if (n_slots == 4'h0) n_slots = 4'h1;
        else if (n_slots > `AFC_MAX_SLOTS) n_slots = `AFC_MAX_SLOTS;
        len22     = (st_q.dec_cfg[`AFC_FIRLEN_MSB:`AFC_FIRLEN_LSB] == `AFC_FIRLEN_22);
        rem_en    = st_q.dec_cfg[`AFC_REMEN_BIT];
        fast      = st_q.rate_cfg[`AFC_RATE_BIT];
        chop_mode = st_q.chop_cfg[`AFC_CHOP_MSB:`AFC_CHOP_LSB];
    end

    assign slow_clock_32k_rise    = SLOW_CLOCK_32K && !st_q.slow_clock_32k_prev;
    assign slot_end     = slow_clock_32k_rise && (st_q.fsm == AFC_FS_SLOT);
    assign settle_start = slot_end && (st_q.slot == n_slots - 4'h1);

    // ------------------------------------------------------------
    // Decimators and chop
    // ------------------------------------------------------------
    afc_decim #(
        .W       (SAMPLE_W)
    ) u_local (
        .clk     (CLK_SYS),
        .rst     (RST),
        .tick    (st_q.conv_tick),
        .mod_bit (LOCAL_MOD_BIT),
        .dump    (slow_clock_32k_rise),
        .len22   (len22),
        .result  (loc_res),
        .valid   (loc_vld)
    );

    afc_decim #(
        .W       (SAMPLE_W)
    ) u_remote (
        .clk     (CLK_SYS),
        .rst     (RST),
        .tick    (st_q.link_tick),
        .mod_bit (st_q.link_bit),
        .dump    (slow_clock_32k_rise && rem_en),
        .len22   (len22),
        .result  (rem_res),
        .valid   (rem_vld)
    );

    afc_chop #(
        .ACC_FRAMES (ACC_FRAMES)
    ) u_chop (
        .clk        (CLK_SYS),
        .rst        (RST),
        .update     (settle_start),
        .mode       (chop_mode),
        .invert     (chop_inv)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d           = st_q;
        st_d.slow_clock_32k_prev = SLOW_CLOCK_32K;
        st_d.ce_start  = 1'h0;
        st_d.ram.we    = 1'h0;
        st_d.conv_tick = 1'h0;
        st_d.link_tick = 1'h0;

        // Converter clock; the decimator counts on its rising edges
        if (st_q.conv_cnt == 4'h0) begin
            st_d.conv_cnt  = fast ? `AFC_CONV_HALF_F : `AFC_CONV_HALF_S;
            st_d.conv_clk  = ~st_q.conv_clk;
            st_d.conv_tick = ~st_q.conv_clk;
        end else begin
            st_d.conv_cnt = st_q.conv_cnt - 4'h1;
        end

        // Slot sequencer
        case (st_q.fsm)
            AFC_FS_SLOT: begin
                if (settle_start) begin
                    st_d.fsm        = AFC_FS_SETTLE;
                    st_d.frame_sync = 1'h1;
                    st_d.ce_start   = 1'h1;
                end else if (slot_end) begin
                    st_d.slot = st_q.slot + 4'h1;
                end
            end
            AFC_FS_SETTLE: begin
                if (slow_clock_32k_rise) begin
                    st_d.fsm        = AFC_FS_SLOT;
                    st_d.slot       = 4'h0;
                    st_d.frame_sync = 1'h0;
                end
            end
            default: begin
                st_d.fsm        = AFC_FS_SLOT;
                st_d.slot       = 4'h0;
                st_d.frame_sync = 1'h0;
            end
        endcase

        // Local settle-cycle dumps carry chop transients and are never stored
        st_d.loc_pend = slot_end;
        if (slot_end) st_d.wr_slot = st_q.slot;

        // Monitor word readout at the start of each engine pass
        if (st_q.ce_start) begin
            st_d.rtm_valid = 1'h1;
            st_d.rtm_idx   = 2'h0;
        end else if (st_q.rtm_valid) begin
            if (st_q.rtm_idx == `AFC_RTM_LAST) st_d.rtm_valid = 1'h0;
            else st_d.rtm_idx = st_q.rtm_idx + 2'h1;
        end

        // RAM port: local samples first, a remote sample waits one free cycle
        if (rem_vld) begin
            st_d.rem_pend = 1'h1;
            st_d.rem_word = sample_word(rem_res);
        end
        if (loc_vld && st_q.loc_pend) begin
            st_d.ram.we   = 1'h1;
            st_d.ram.addr = `AFC_RAM_BASE + {12'h000, st_q.wr_slot};
            st_d.ram.data = sample_word(loc_res);
        end else if (st_q.rem_pend && !rem_vld) begin
            st_d.ram.we   = 1'h1;
            st_d.ram.addr = `AFC_RAM_REMOTE;
            st_d.ram.data = st_q.rem_word;
            st_d.rem_pend = 1'h0;
        end

        // Remote link: drive a power pulse, then release and sample the stream
        if (rem_en) begin
            if (st_q.pulse_cnt == 8'h0) begin
                st_d.pulse_cnt = `AFC_PULSE_HALF;
                st_d.pulse_ph  = ~st_q.pulse_ph;
                if (!st_q.pulse_ph) begin
                    st_d.link_tick = 1'h1;
                    st_d.link_bit  = REMOTE_LINK_POS_I && !REMOTE_LINK_NEG_I;
                end
            end else begin
                st_d.pulse_cnt = st_q.pulse_cnt - 8'h1;
            end
            st_d.pos.o  = st_d.pulse_ph;
            st_d.pos.oe = st_d.pulse_ph;
            st_d.neg.o  = 1'h0;
            st_d.neg.oe = st_d.pulse_ph;
        end else begin
            st_d.pulse_cnt = 8'h0;
            st_d.pulse_ph  = 1'h0;
            st_d.pos       = '0;
            st_d.neg       = '0;
        end

        // Register port
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                `AFC_ADDR_FRAME: st_d.frame_cfg = REG_REQ.wdata;
                `AFC_ADDR_CHOP:  st_d.chop_cfg  = REG_REQ.wdata;
                `AFC_ADDR_DEC:   st_d.dec_cfg   = REG_REQ.wdata;
                `AFC_ADDR_RATE:  st_d.rate_cfg  = REG_REQ.wdata;
                default:         ;
            endcase
        end
        st_d.rdata = 8'h00;
        if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                `AFC_ADDR_FRAME: st_d.rdata = st_q.frame_cfg;
                `AFC_ADDR_CHOP:  st_d.rdata = st_q.chop_cfg;
                `AFC_ADDR_DEC:   st_d.rdata = st_q.dec_cfg;
                `AFC_ADDR_RATE:  st_d.rdata = st_q.rate_cfg;
                `AFC_ADDR_STAT:  st_d.rdata = {1'h0, st_q.frame_sync, chop_inv, rem_en,
                                               st_q.fsm, st_q.slot[2:0]};
                default:         st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_q           <= '0;
            st_q.frame_cfg <= `AFC_RST_FRAME;
            st_q.chop_cfg  <= `AFC_RST_CHOP;
            st_q.dec_cfg   <= `AFC_RST_DEC;
            st_q.rate_cfg  <= `AFC_RST_RATE;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign REG_RDATA       = st_q.rdata;
    assign CONVERTER_CLOCK = st_q.conv_clk;
    // High swaps the reference amplifier input pair
    assign CHOP_INVERT     = chop_inv;
    assign FRAME_SYNC      = st_q.frame_sync;
    assign CE_START        = st_q.ce_start;
    assign RTM_VALID       = st_q.rtm_valid;
    assign RTM_INDEX       = st_q.rtm_idx;
    assign RAM_WR          = st_q.ram;
    assign REMOTE_LINK_POS = st_q.pos;
    assign REMOTE_LINK_NEG = st_q.neg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_SETTLE_ONE: assert property (@(posedge CLK_SYS) disable iff (RST)
        (st_q.fsm == AFC_FS_SETTLE && slow_clock_32k_rise) |=> (st_q.fsm == AFC_FS_SLOT && st_q.slot == 4'h0))
        else $error("settle cycle did not end at the next slow edge");
    AST_SYNC_SETTLE: assert property (@(posedge CLK_SYS) disable iff (RST)
        settle_start |=> FRAME_SYNC throughout (st_q.fsm == AFC_FS_SETTLE))
        else $error("frame sync not high in settle cycle");
    AST_SYNC_LOW: assert property (@(posedge CLK_SYS) disable iff (RST)
        (st_q.fsm == AFC_FS_SLOT) |-> !FRAME_SYNC)
        else $error("frame sync high in an ordinary slot");
    AST_CE_START: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(FRAME_SYNC) |-> CE_START)
        else $error("engine pass not started on frame sync");
    AST_RTM_FOUR: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE_START |=> RTM_VALID [*4] ##1 !RTM_VALID)
        else $error("monitor readout not four words");
    AST_CHOP_FIXED: assert property (@(posedge CLK_SYS) disable iff (RST)
        (settle_start && chop_mode == `AFC_CHOP_NEG) |=> CHOP_INVERT)
        else $error("chop mode 10 did not hold invert high");
    AST_CHOP_STILL: assert property (@(posedge CLK_SYS) disable iff (RST)
        !settle_start |=> $stable(CHOP_INVERT))
        else $error("chop invert changed outside settle start");
    AST_SHIFT9: assert property (@(posedge CLK_SYS) disable iff (RST)
        RAM_WR.we |-> (RAM_WR.data[`AFC_SAMPLE_SHIFT-1:0] == '0))
        else $error("stored sample not shifted left");
    AST_SLOT_WR: assert property (@(posedge CLK_SYS) disable iff (RST)
        slot_end |=> ##1 (RAM_WR.we && RAM_WR.addr == `AFC_RAM_BASE + {12'h000, $past(st_q.slot, 2)}))
        else $error("slot sample not written to its word");
    AST_RESET_CHOP: assert property (@(posedge CLK_SYS)
        RST |=> !CHOP_INVERT)
        else $error("chop invert not low after reset");
endmodule
`default_nettype wire

// >>> dv/afc_partner.sv
// Far side model: compute engine RAM sink and remote sensor on the balanced link.
// Assumes RAM writes are one-cycle strobes in the CLK_SYS domain.
`timescale 1ns/1ns
`default_nettype none
module afc_partner (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire afc_pkg::afc_ram_wr_t ram_wr,
    input  wire afc_pkg::afc_pin_t    pos,
    input  wire afc_pkg::afc_pin_t    neg,
    output logic                      pos_i,
    output logic                      neg_i,
    output int                        n_local,
    output int                        n_remote,
    output logic [31:0]               last_data
);
    logic bit_q;
    // Released pair carries a changing sensor pattern, never the last driven level
    assign pos_i = pos.oe ? pos.o : bit_q;
    assign neg_i = neg.oe ? neg.o : ~bit_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            bit_q    <= 1'b0;
            n_local  <= 0;
            n_remote <= 0;
        end else begin
            bit_q <= ~bit_q;
            if (ram_wr.we && ram_wr.addr == 16'h0010) begin
                n_remote <= n_remote + 1;
            end else if (ram_wr.we) begin
                n_local   <= n_local + 1;
                last_data <= ram_wr.data;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/adc_frame_chop_control_test.sv
// Self-checking bench of the frame/chop control with RAM and remote sensor model.
// Assumes the 32 kHz input is a level the bench toggles every 156 system cycles.
`timescale 1ns/1ns
`default_nettype none
module adc_frame_chop_control_test;
    import afc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, pos_i, neg_i, cclk, inv, fs, ces, rtv;
    logic mod = 1'b1;
    logic [7:0] rdata;
    logic [1:0] rtm_idx;
    afc_reg_req_t req = '0;
    afc_ram_wr_t ram;
    afc_pin_t lp, ln;
    int n_fail = 0, checks_done = 0, n_loc, n_rem, slow_cnt = 0;
    logic [31:0] ldata;
    logic inv_prev;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        slow_cnt <= (slow_cnt == 155) ? 0 : slow_cnt + 1;
        if (slow_cnt == 155) slow <= ~slow;
    end
    afc_frame_ctrl #(.ACC_FRAMES(2), .SAMPLE_W(22)) u_dut (.CLK_SYS(clk), .RST(rst),
        .REG_REQ(req), .REG_RDATA(rdata), .SLOW_CLOCK_32K(slow), .LOCAL_MOD_BIT(mod),
        .CONVERTER_CLOCK(cclk), .CHOP_INVERT(inv), .FRAME_SYNC(fs), .CE_START(ces),
        .RTM_VALID(rtv), .RTM_INDEX(rtm_idx), .RAM_WR(ram), .REMOTE_LINK_POS_I(pos_i),
        .REMOTE_LINK_NEG_I(neg_i), .REMOTE_LINK_POS(lp), .REMOTE_LINK_NEG(ln));
    afc_partner u_far (.clk(clk), .rst(rst), .ram_wr(ram), .pos(lp), .neg(ln),
        .pos_i(pos_i), .neg_i(neg_i), .n_local(n_loc), .n_remote(n_rem), .last_data(ldata));
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk) req <= '0;
    endtask
    task automatic reg_rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk) req <= '0;
        @(posedge clk) check_eq({24'h0, rdata}, {24'h0, e}, "register read");
    endtask
    // Converter clock period in system cycles, rise to rise
    task automatic conv_period(input int exp);
        int n;
        n = 0;
        while (cclk !== 1'b0 && n < 50) begin @(posedge clk); n++; end
        while (cclk !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        n = 0;
        @(posedge clk);
        while (cclk !== 1'b0 && n < 50) begin @(posedge clk); n++; end
        while (cclk !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        check_eq(n + 1, exp, "converter clock period");
    endtask
    // One frame: wait for frame sync, time it, count monitor readout and slot writes
    task automatic frame(input int slots);
        int n, nrtm, isum, loc0;
        n = 0;
        nrtm = 0;
        isum = 0;
        loc0 = n_loc;
        while (fs !== 1'b1 && n < 5000) begin @(posedge clk); n++; end
        check_eq(ces, 1'b1, "compute start with sync rise");
        n = 0;
        while (fs === 1'b1 && n < 400) begin
            nrtm += (rtv === 1'b1);
            isum += (rtv === 1'b1) ? rtm_idx : 0;
            @(posedge clk);
            n++;
        end
        check_eq(n, 312, "sync width one slow period");
        check_eq(nrtm, 4, "monitor words per pass");
        check_eq(isum, 6, "monitor word order");
        // The last slot's word lands after sync rises, so count once sync is over
        if (slots > 0) check_eq(n_loc - loc0, slots, "slot writes per frame");
    endtask
    // Link pulse phase: positive pin driven high, negative pin driven low
    task automatic link_drive;
        int n;
        n = 0;
        while (lp.oe !== 1'b1 && n < 40) begin @(posedge clk); n++; end
        check_eq({lp.o, ln.oe, ln.o}, 3'b110, "link pulse drive");
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        reg_rd_chk(16'h2100, 8'hB0);
        reg_rd_chk(16'h2106, 8'h00);
        reg_rd_chk(16'h210C, 8'h02);
        reg_rd_chk(16'h2108, 8'h00);
        check_eq(inv, 1'b0, "invert after reset");
        reg_wr(16'h2100, 8'h20);
        reg_wr(16'h210C, 8'h22);
        conv_period(8);
        reg_wr(16'h2110, 8'h01);
        conv_period(4);
        reg_rd_chk(16'h2110, 8'h01);
        frame(0);
        frame(2);
        check_eq(inv, 1'b1, "auto chop first interval end");
        check_eq(ldata[8:0], 9'h000, "sample shifted left nine");
        check_eq(($signed(ldata) >>> 9) <= 32'sd1048575, 1'b1, "21-bit range");
        check_eq(($signed(ldata) >>> 9) inside {[77:78]}, 1'b1, "slot sample value");
        frame(2);
        frame(2);
        check_eq(inv, 1'b0, "auto chop second interval end");
        check_eq(n_rem > 0, 1'b1, "remote samples written");
        check_eq(n_rem > 0 && lp.oe !== 1'bx, 1'b1, "link pins active");
        link_drive();
        reg_wr(16'h2106, 8'h0C);
        frame(2);
        inv_prev = inv;
        frame(2);
        check_eq(inv, inv_prev, "hold mode keeps invert at interval end");
        reg_wr(16'h2106, 8'h04);
        frame(2);
        check_eq(inv, 1'b0, "positive chop");
        reg_wr(16'h2106, 8'h08);
        frame(2);
        check_eq(inv, 1'b1, "reverse chop");
        reg_rd_chk(16'h2114, 8'h30);
        mod <= 1'b0;
        frame(2);
        check_eq(($signed(ldata) >>> 9) inside {[-78:-77]}, 1'b1, "negative sample");
        report_and_stop();
    end
endmodule
`default_nettype wire
